// [bench/ueaf_host_model.sv]
`timescale 1ns/10ps
module ueaf_host_model (
   input wire logic clk_i,
   output logic tok_valid_o,
   output logic [1:0] tok_kind_o,
   output logic [6:0] tok_addr_o,
   output logic [2:0] tok_ep_o,
   output logic [10:0] tok_frame_o,
   output logic stall_sent_o,
   output logic [2:0] stall_ep_o
);
   initial begin
      tok_valid_o = 1'b0;
      tok_kind_o = 2'h0;
      tok_addr_o = 7'h55;
      tok_ep_o = 3'h0;
      tok_frame_o = 11'h2AA;
      stall_sent_o = 1'b0;
      stall_ep_o = 3'h0;
   end
   // Address, endpoint and frame fields are inverted once a token is over (kind is kept), so nothing leans on stale values
   task automatic send_token(input logic [1:0] k, input logic [6:0] a, input logic [2:0] e,
                             input logic [10:0] f);
      @(posedge clk_i);
      tok_valid_o <= 1'b1;
      tok_kind_o <= k;
      tok_addr_o <= a;
      tok_ep_o <= e;
      tok_frame_o <= f;
      @(posedge clk_i);
      tok_valid_o <= 1'b0;
      tok_addr_o <= ~a;
      tok_ep_o <= ~e;
      tok_frame_o <= ~f;
   endtask
   task automatic send_stall(input logic [2:0] e);
      @(posedge clk_i);
      stall_sent_o <= 1'b1;
      stall_ep_o <= e;
      @(posedge clk_i);
      stall_sent_o <= 1'b0;
      stall_ep_o <= ~e;
   endtask
endmodule

// [bench/usb_endpoint_address_frame_regs_bench.sv]
`timescale 1ns/10ps
module usb_endpoint_address_frame_regs_bench;
   logic clk, rst, we, stb, bus_rst, susp, eram_we, ack, tv, ss, rv, rx, rs, rh, fv;
   logic [3:0] sel;
   logic [11:0] adr;
   logic [31:0] wdat, rdat, bus_rd;
   logic [7:0] eram_adr, eram_wd, eram_rd;
   logic [1:0] tk;
   logic [6:0] ta;
   logic [2:0] te, se;
   logic [10:0] tf;
   int fails, tests_run;
   ueaf_regs dut (.SYS_CLK_I(clk), .RST_I(rst), .WB_ADR_I(adr), .WB_DAT_I(wdat),
      .WB_DAT_O(bus_rd), .WB_WE_I(we), .WB_SEL_I(sel), .WB_STB_I(stb), .WB_CYC_I(stb),
      .WB_ACK_O(ack), .BUS_RESET_I(bus_rst), .SUSPEND_I(susp), .TOK_VALID_I(tv),
      .TOK_KIND_I(tk), .TOK_ADDR_I(ta), .TOK_EP_I(te), .TOK_FRAME_I(tf), .STALL_SENT_I(ss),
      .STALL_EP_I(se), .ERAM_ADDR_I(eram_adr), .ERAM_WE_I(eram_we), .ERAM_DAT_I(eram_wd),
      .ERAM_DAT_O(eram_rd), .RSP_VALID_O(rv), .RSP_XFER_O(rx), .RSP_STALL_O(rs),
      .RSP_HSHK_O(rh), .FRAME_VALID_O(fv));
   ueaf_host_model host (.clk_i(clk), .tok_valid_o(tv), .tok_kind_o(tk), .tok_addr_o(ta),
      .tok_ep_o(te), .tok_frame_o(tf), .stall_sent_o(ss), .stall_ep_o(se));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic print_verdict;
      if (fails == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // Holds the request until ack is seen; read data is taken at that same edge
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) fails++;
      rdat = bus_rd;
      stb <= 1'b0;
      wdat <= ~d;
   endtask
   task automatic eram(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      eram_we <= w;
      eram_adr <= a;
      eram_wd <= d;
      @(posedge clk);
      eram_we <= 1'b0;
      #1;
   endtask
   task automatic t_reset;
      for (int i = 0; i < 11; i++) begin
         wb(1'b0, 12'(4 * i), 32'h0);
         chk("reset value", 32'h0, rdat);
      end
   endtask
   task automatic t_decide;
      logic [4:0] c;
      logic o, i, hl, ok;
      for (int k = 0; k < 32; k++) begin
         c = k[4:0];
         wb(1'b1, 12'h014, {27'h0, c});
         wb(1'b0, 12'h014, 32'h0);
         chk("ep ctrl", {27'h0, c}, rdat);
         o = c[2];
         i = c[1];
         hl = c[0] & (o | i);
         for (int j = 0; j < 3; j++) begin
            ok = (j == 0) ? o : (j == 1) ? i : (o & ~(i & c[3]));
            host.send_token(j[1:0], 7'h2A, 3'h5, 11'h0);
            #1;
            chk("answer", {28'h0, 1'b1, ok & ~hl, hl, c[4] & (ok | hl)},
                {28'h0, rv, rx, rs, rh});
         end
      end
      host.send_token(2'h0, 7'h2B, 3'h5, 11'h0);
      #1;
      chk("foreign token", 32'h0, {31'h0, rv});
   endtask
   task automatic t_stall;
      wb(1'b1, 12'h00C, 32'h0000_0004);
      host.send_stall(3'h3);
      wb(1'b0, 12'h00C, 32'h0);
      chk("stall set", 32'h0000_0005, rdat);
      host.send_token(2'h0, 7'h2A, 3'h3, 11'h0);
      #1;
      chk("stall answer", 32'h0000_0002, {30'h0, rs, rx});
      wb(1'b1, 12'h00C, 32'h0000_0004);
      wb(1'b0, 12'h00C, 32'h0);
      chk("stall cleared", 32'h0000_0004, rdat);
   endtask
   task automatic t_frame;
      // Address deliberately foreign: the frame must load regardless
      host.send_token(2'h3, 7'h11, 3'h0, 11'h5A3);
      #1;
      chk("sof answer", 32'h0, {31'h0, rv});
      wb(1'b1, 12'h024, 32'h0000_00FF);
      wb(1'b1, 12'h028, 32'h0000_0000);
      wb(1'b0, 12'h024, 32'h0);
      chk("frame low", 32'h0000_00A3, rdat);
      wb(1'b0, 12'h028, 32'h0);
      chk("frame high", 32'h0000_0005, rdat);
      susp <= 1'b1;
      repeat (2) @(posedge clk);
      chk("frame valid", 32'h0, {31'h0, fv});
      wb(1'b0, 12'h02C, 32'h0);
      chk("suspend status", 32'h0000_0001, rdat);
      susp <= 1'b0;
      repeat (2) @(posedge clk);
      chk("frame valid", 32'h1, {31'h0, fv});
   endtask
   task automatic t_ram;
      wb(1'b1, 12'h204, 32'h4433_2211);
      eram(1'b0, 8'h06, 8'h00);
      chk("engine read", 32'h0000_0033, {24'h0, eram_rd});
      wb(1'b1, 12'h280, 32'h0807_0605);
      eram(1'b1, 8'h81, 8'h5C);
      wb(1'b0, 12'h280, 32'h0);
      chk("core read", 32'h0807_5C05, rdat);
      sel <= 4'h2;
      wb(1'b1, 12'h280, 32'hFFFF_FFFF);
      sel <= 4'hF;
      wb(1'b0, 12'h280, 32'h0);
      chk("lane write", 32'h0807_FF05, rdat);
      wb(1'b0, 12'h100, 32'h0);
      chk("unmapped", 32'h0, rdat);
   endtask
   initial begin
      {rst, we, stb, bus_rst, susp, eram_we, sel, adr, wdat, eram_adr, eram_wd} = '0;
      rst = 1'b1;
      sel = 4'hF;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      wb(1'b1, 12'h020, 32'h0000_002A);
      t_decide();
      t_stall();
      t_frame();
      @(posedge clk);
      bus_rst <= 1'b1;
      @(posedge clk);
      bus_rst <= 1'b0;
      wb(1'b0, 12'h020, 32'h0);
      chk("address after bus reset", 32'h0, rdat);
      t_ram();
      wb(1'b1, 12'h020, 32'h0000_002A);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      print_verdict();
   end
   initial begin
      #1_000_000;
      fails++;
      print_verdict();
   end
endmodule

// [rtl/ueaf_pkg.sv]
package ueaf_pkg;
   localparam int NUM_EP = 8;
   localparam int EP_W = 5;
   localparam int FRAME_W = 11;
   localparam int DEV_ADDR_W = 7;
   localparam logic [11:0] EP_CTRL_BASE = 12'h000;
   localparam logic [11:0] DEV_ADDR_OFS = 12'h020;
   localparam logic [11:0] FRM_LOW_OFS = 12'h024;
   localparam logic [11:0] FRM_HIGH_OFS = 12'h028;
   localparam logic [11:0] USB_STAT_OFS = 12'h02C;
   localparam logic [11:0] RAM_BASE = 12'h200;
   localparam logic [11:0] RAM_LAST = 12'h2FF;
   localparam logic [11:0] BD_AREA_LAST = 12'h27F;
   localparam int EP_HSHK_BIT = 4;
   localparam int EP_SETUP_DIS_BIT = 3;
   localparam int EP_OUT_BIT = 2;
   localparam int EP_IN_BIT = 1;
   localparam int EP_HALT_BIT = 0;
   localparam logic [4:0] EP_CTRL_RST = 5'h00;
   localparam logic [6:0] DEV_ADDR_RST = 7'h00;
   localparam logic [10:0] FRAME_RST = 11'h000;
   localparam logic [1:0] TOK_OUT = 2'h0;
   localparam logic [1:0] TOK_IN = 2'h1;
   localparam logic [1:0] TOK_SETUP = 2'h2;
   localparam logic [1:0] TOK_SOF = 2'h3;
endpackage

// [rtl/ueaf_regs.sv]
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module ueaf_regs (
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic [11:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   input wire logic WB_WE_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic WB_STB_I,
   input wire logic WB_CYC_I,
   output logic WB_ACK_O,
   input wire logic BUS_RESET_I,
   input wire logic SUSPEND_I,
   input wire logic TOK_VALID_I,
   input wire logic [1:0] TOK_KIND_I,
   input wire logic [6:0] TOK_ADDR_I,
   input wire logic [2:0] TOK_EP_I,
   input wire logic [10:0] TOK_FRAME_I,
   input wire logic STALL_SENT_I,
   input wire logic [2:0] STALL_EP_I,
   input wire logic [7:0] ERAM_ADDR_I,
   input wire logic ERAM_WE_I,
   input wire logic [7:0] ERAM_DAT_I,
   output logic [7:0] ERAM_DAT_O,
   output logic RSP_VALID_O,
   output logic RSP_XFER_O,
   output logic RSP_STALL_O,
   output logic RSP_HSHK_O,
   output logic FRAME_VALID_O
);
   logic [4:0] ep_ctrl [ueaf_pkg::NUM_EP];
   logic [6:0] dev_addr;
   logic [10:0] frame_num;
   logic [7:0] ram [256];
   logic bus_req;
   logic wr_en;
   logic ram_hit;
   logic [4:0] tok_ctrl;
   logic tok_match;
   logic tok_sof;
   logic any_dir;
   logic halted;
   logic dir_ok;

   function automatic logic word_hit(input logic [11:0] adr, input logic [11:0] ofs);
      word_hit = (adr[11:2] == ofs[11:2]);
   endfunction

   function automatic logic [11:0] ep_ofs(input int idx);
      ep_ofs = ueaf_pkg::EP_CTRL_BASE + 12'(idx * 4);
   endfunction

   assign bus_req = WB_CYC_I & WB_STB_I;
   // Write lands on the edge where the master samples ack
   assign wr_en = bus_req & WB_WE_I & WB_ACK_O;
   assign ram_hit = (WB_ADR_I >= ueaf_pkg::RAM_BASE) && (WB_ADR_I <= ueaf_pkg::RAM_LAST);

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         WB_ACK_O <= 1'b0;
      end else begin
         WB_ACK_O <= bus_req & ~WB_ACK_O;
      end
   end

   // Endpoint control registers
   for (genvar g = 0; g < ueaf_pkg::NUM_EP; g++) begin : g_ep
      logic ep_wr;
      assign ep_wr = wr_en && WB_SEL_I[0] && word_hit(WB_ADR_I, ep_ofs(g));
      always_ff @(posedge SYS_CLK_I) begin
         if (RST_I) begin
            ep_ctrl[g] <= ueaf_pkg::EP_CTRL_RST;
         end else begin
            if (ep_wr) begin
               ep_ctrl[g][4:1] <= WB_DAT_I[4:1];
            end
            // Engine stall wins over a firmware clear in the same cycle
            if (STALL_SENT_I && (STALL_EP_I == 3'(g))) begin
               ep_ctrl[g][ueaf_pkg::EP_HALT_BIT] <= 1'b1;
            end else if (ep_wr) begin
               ep_ctrl[g][ueaf_pkg::EP_HALT_BIT] <= WB_DAT_I[0];
            end
         end
      end
      // Apart from RST_I, only a firmware write may take the halt bit down again
      a_halt_kept: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
         (ep_ctrl[g][ueaf_pkg::EP_HALT_BIT] && !ep_wr) |=> ep_ctrl[g][ueaf_pkg::EP_HALT_BIT])
         else $error("halt bit dropped without a write");
      a_ctrl_write: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
         (ep_wr && !(STALL_SENT_I && STALL_EP_I == 3'(g)))
         |=> ep_ctrl[g] == $past(WB_DAT_I[4:0]))
         else $error("endpoint control write lost");
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I || BUS_RESET_I) begin
         dev_addr <= ueaf_pkg::DEV_ADDR_RST;
      end else if (wr_en && WB_SEL_I[0] && word_hit(WB_ADR_I, ueaf_pkg::DEV_ADDR_OFS)) begin
         dev_addr <= WB_DAT_I[6:0];
      end
   end

   // Frame number has no bus write path at all
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         frame_num <= ueaf_pkg::FRAME_RST;
      end else if (tok_sof) begin
         frame_num <= TOK_FRAME_I;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         FRAME_VALID_O <= 1'b0;
      end else begin
         FRAME_VALID_O <= ~SUSPEND_I;
      end
   end

   // No hardware lock on shared RAM; ownership is left to firmware.
   // Engine wins a same-byte collision.
   always_ff @(posedge SYS_CLK_I) begin
      for (int b = 0; b < 4; b++) begin
         if (wr_en && ram_hit && WB_SEL_I[b]) begin
            ram[{WB_ADR_I[7:2], 2'(b)}] <= WB_DAT_I[8*b +: 8];
         end
      end
      if (ERAM_WE_I) begin
         ram[ERAM_ADDR_I] <= ERAM_DAT_I;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         ERAM_DAT_O <= 8'h00;
      end else begin
         ERAM_DAT_O <= ram[ERAM_ADDR_I];
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         WB_DAT_O <= 32'h0000_0000;
      end else if (bus_req && !WB_ACK_O) begin
         WB_DAT_O <= 32'h0000_0000;
         for (int e = 0; e < ueaf_pkg::NUM_EP; e++) begin
            if (word_hit(WB_ADR_I, ep_ofs(e))) begin
               WB_DAT_O[4:0] <= ep_ctrl[e];
            end
         end
         if (word_hit(WB_ADR_I, ueaf_pkg::DEV_ADDR_OFS)) begin
            WB_DAT_O[6:0] <= dev_addr;
         end
         if (word_hit(WB_ADR_I, ueaf_pkg::FRM_LOW_OFS)) begin
            WB_DAT_O[7:0] <= frame_num[7:0];
         end
         if (word_hit(WB_ADR_I, ueaf_pkg::FRM_HIGH_OFS)) begin
            WB_DAT_O[2:0] <= frame_num[10:8];
         end
         if (word_hit(WB_ADR_I, ueaf_pkg::USB_STAT_OFS)) begin
            WB_DAT_O[0] <= SUSPEND_I;
         end
         if (ram_hit) begin
            WB_DAT_O <= {ram[{WB_ADR_I[7:2], 2'h3}], ram[{WB_ADR_I[7:2], 2'h2}],
                         ram[{WB_ADR_I[7:2], 2'h1}], ram[{WB_ADR_I[7:2], 2'h0}]};
         end
      end
   end

   // Token decisions
   // Answers are registered, so the engine sees them one cycle after the token;
   // a token in flight during a control write uses the old control bits
   assign tok_ctrl = ep_ctrl[TOK_EP_I];
   assign tok_sof = TOK_VALID_I && (TOK_KIND_I == ueaf_pkg::TOK_SOF);
   assign tok_match = TOK_VALID_I && !tok_sof && (TOK_ADDR_I == dev_addr);
   assign any_dir = tok_ctrl[ueaf_pkg::EP_OUT_BIT] | tok_ctrl[ueaf_pkg::EP_IN_BIT];
   assign halted = tok_ctrl[ueaf_pkg::EP_HALT_BIT] & any_dir;

   always_comb begin
      case (TOK_KIND_I)
         ueaf_pkg::TOK_OUT: dir_ok = tok_ctrl[ueaf_pkg::EP_OUT_BIT];
         ueaf_pkg::TOK_IN: dir_ok = tok_ctrl[ueaf_pkg::EP_IN_BIT];
         ueaf_pkg::TOK_SETUP: dir_ok = tok_ctrl[ueaf_pkg::EP_OUT_BIT] &&
            !(tok_ctrl[ueaf_pkg::EP_IN_BIT] && tok_ctrl[ueaf_pkg::EP_SETUP_DIS_BIT]);
         default: dir_ok = 1'b0;
      endcase
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         RSP_VALID_O <= 1'b0;
         RSP_XFER_O <= 1'b0;
         RSP_STALL_O <= 1'b0;
         RSP_HSHK_O <= 1'b0;
      end else begin
         RSP_VALID_O <= tok_match;
         RSP_XFER_O <= tok_match && dir_ok && !halted;
         RSP_STALL_O <= tok_match && halted;
         RSP_HSHK_O <= tok_match && tok_ctrl[ueaf_pkg::EP_HSHK_BIT] && (dir_ok || halted);
      end
   end

   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I);

   a_ep_upper_zero: assert property (
      (bus_req && !WB_ACK_O && !WB_WE_I && WB_ADR_I < ueaf_pkg::DEV_ADDR_OFS)
      |=> WB_ACK_O && WB_DAT_O[31:5] == 27'h000_0000)
      else $error("endpoint read shows upper bits");
   a_hshk_off: assert property (
      (tok_match && !tok_ctrl[ueaf_pkg::EP_HSHK_BIT]) |=> !RSP_HSHK_O)
      else $error("handshake given while disabled");
   a_setup_refused: assert property (
      (tok_match && TOK_KIND_I == ueaf_pkg::TOK_SETUP && tok_ctrl[3:1] == 3'h7) |=> !RSP_XFER_O)
      else $error("setup accepted while disabled");
   a_out_gated: assert property (
      (tok_match && TOK_KIND_I == ueaf_pkg::TOK_OUT && !tok_ctrl[ueaf_pkg::EP_OUT_BIT])
      |=> RSP_VALID_O && !RSP_XFER_O)
      else $error("out transfer on disabled endpoint");
   a_in_gated: assert property (
      (tok_match && TOK_KIND_I == ueaf_pkg::TOK_IN && !tok_ctrl[ueaf_pkg::EP_IN_BIT])
      |=> !RSP_XFER_O)
      else $error("in transfer on disabled endpoint");
   a_halt_ignored: assert property (
      (tok_match && !any_dir) |=> !RSP_STALL_O && !RSP_XFER_O)
      else $error("stall on disabled endpoint");
   a_addr_reset: assert property (
      BUS_RESET_I |=> dev_addr == ueaf_pkg::DEV_ADDR_RST)
      else $error("address kept over bus reset");
   a_sof_load: assert property (
      tok_sof |=> frame_num == $past(TOK_FRAME_I))
      else $error("frame number not loaded");
   a_frame_ro: assert property (
      (!tok_sof && wr_en) |=> $stable(frame_num))
      else $error("frame number changed by write");
   a_susp_frame: assert property (
      SUSPEND_I |=> !FRAME_VALID_O)
      else $error("frame valid while suspended");
   a_eram_write: assert property (
      ERAM_WE_I ##1 !ERAM_WE_I |-> ##1 (ERAM_DAT_O == $past(ERAM_DAT_I, 2)
         || $past(ERAM_ADDR_I, 1) != $past(ERAM_ADDR_I, 2)))
      else $error("engine ram write lost");
   a_stall_sets: assert property (
      STALL_SENT_I |=> ep_ctrl[$past(STALL_EP_I)][ueaf_pkg::EP_HALT_BIT])
      else $error("stall did not set halt bit");
   // Token answers, one cycle after the edge that takes the token
   a_hshk_on: assert property (
      (tok_match && tok_ctrl[ueaf_pkg::EP_HSHK_BIT] && dir_ok) |=> RSP_HSHK_O)
      else $error("handshake missing while enabled");
   a_hshk_stall: assert property (
      (tok_match && tok_ctrl[ueaf_pkg::EP_HSHK_BIT] && halted) |=> RSP_HSHK_O && RSP_STALL_O)
      else $error("stall answer without handshake");
   a_setup_taken: assert property (
      (tok_match && TOK_KIND_I == ueaf_pkg::TOK_SETUP && tok_ctrl[3:0] == 4'h6) |=> RSP_XFER_O)
      else $error("setup refused while allowed");
   a_out_taken: assert property (
      (tok_match && TOK_KIND_I == ueaf_pkg::TOK_OUT && tok_ctrl[ueaf_pkg::EP_OUT_BIT]
       && !tok_ctrl[ueaf_pkg::EP_HALT_BIT]) |=> RSP_XFER_O)
      else $error("out transfer refused while enabled");
   a_in_taken: assert property (
      (tok_match && TOK_KIND_I == ueaf_pkg::TOK_IN && tok_ctrl[ueaf_pkg::EP_IN_BIT]
       && !tok_ctrl[ueaf_pkg::EP_HALT_BIT]) |=> RSP_XFER_O)
      else $error("in transfer refused while enabled");
   a_stall_shown: assert property (
      (tok_match && tok_ctrl[ueaf_pkg::EP_HALT_BIT] && any_dir) |=> RSP_STALL_O && !RSP_XFER_O)
      else $error("stalled endpoint not answered with stall");
   a_addr_match: assert property (
      (TOK_VALID_I && !tok_sof && TOK_ADDR_I != dev_addr) |=> !RSP_VALID_O)
      else $error("token for another address answered");
   a_idle_quiet: assert property (
      !TOK_VALID_I |=> !RSP_VALID_O && !RSP_XFER_O && !RSP_STALL_O && !RSP_HSHK_O)
      else $error("answer given without a token");
   // Register writes and reads: read data is caught at the request edge and stands with ack
   a_addr_write: assert property (
      (wr_en && WB_SEL_I[0] && word_hit(WB_ADR_I, ueaf_pkg::DEV_ADDR_OFS) && !BUS_RESET_I)
      |=> dev_addr == $past(WB_DAT_I[6:0]))
      else $error("device address write lost");
   a_addr_read: assert property (
      (bus_req && !WB_ACK_O && word_hit(WB_ADR_I, ueaf_pkg::DEV_ADDR_OFS))
      |=> WB_DAT_O == {25'h000_0000, $past(dev_addr)})
      else $error("device address read wrong");
   a_frame_low_read: assert property (
      (bus_req && !WB_ACK_O && word_hit(WB_ADR_I, ueaf_pkg::FRM_LOW_OFS))
      |=> WB_DAT_O == {24'h00_0000, $past(frame_num[7:0])})
      else $error("frame low byte read wrong");
   a_frame_high_read: assert property (
      (bus_req && !WB_ACK_O && word_hit(WB_ADR_I, ueaf_pkg::FRM_HIGH_OFS))
      |=> WB_DAT_O == {29'h0000_0000, $past(frame_num[10:8])})
      else $error("frame high bits read wrong");
   a_status_read: assert property (
      (bus_req && !WB_ACK_O && word_hit(WB_ADR_I, ueaf_pkg::USB_STAT_OFS))
      |=> WB_DAT_O == {31'h0000_0000, $past(SUSPEND_I)})
      else $error("suspend status read wrong");
   a_frame_hold: assert property (
      !tok_sof |=> $stable(frame_num))
      else $error("frame number moved without a start of frame");
   a_sof_silent: assert property (
      tok_sof |=> !RSP_VALID_O && !RSP_XFER_O)
      else $error("start of frame answered as a transfer");
   // Sampled reset keeps the release edge out: the flag is still low there
   a_fv_running: assert property (
      (!SUSPEND_I && !RST_I) |=> FRAME_VALID_O)
      else $error("frame not valid while running");
endmodule
